// ==== hw/sbmd_pkg.sv ====
// Purpose: Shared constants for the SRAM bank mode decoder
// Assumes: 32-bit byte addresses, 32-bit data words, one parity bit per byte
// Notes:   Physical word indices place the eight banks back to back in one array
`default_nettype none

package sbmd_pkg;

  // Mode selection codes
  localparam logic [1:0]  SBMD_MODE0      = 2'h0;  // Instruction space on, cache off
  localparam logic [1:0]  SBMD_MODE1      = 2'h1;  // Instruction space on, cache on
  localparam logic [1:0]  SBMD_MODE2      = 2'h2;  // Instruction space off, cache off
  localparam logic [1:0]  SBMD_MODE3      = 2'h3;  // Instruction space off, cache on
  localparam logic [1:0]  SBMD_MODE_RST   = SBMD_MODE0;

  // Mode bit positions
  localparam int          SBMD_MODE_NOI   = 1;     // Set when instruction space is off
  localparam int          SBMD_MODE_CACHE = 0;     // Set when bank 2 is cache

  // Instruction space windows
  localparam logic [31:0] SBMD_I_B1_LO    = 32'h1000_0000;
  localparam logic [31:0] SBMD_I_B1_HI    = 32'h1000_2FFF;
  localparam logic [31:0] SBMD_I_B7_LO    = 32'h1000_3000;
  localparam logic [31:0] SBMD_I_B7_HI    = 32'h1000_6FFF;
  localparam logic [31:0] SBMD_I_B2_LO    = 32'h1000_7000;
  localparam logic [31:0] SBMD_I_B2_HI    = 32'h1000_7FFF;

  // Data space windows
  localparam logic [31:0] SBMD_D_B0_LO    = 32'h2000_0000;
  localparam logic [31:0] SBMD_D_B0_HI    = 32'h2000_3FFF;
  localparam logic [31:0] SBMD_D_B1_LO    = 32'h2000_4000;
  localparam logic [31:0] SBMD_D_B1_HI    = 32'h2000_6FFF;
  localparam logic [31:0] SBMD_D_B2_LO    = 32'h2000_7000;
  localparam logic [31:0] SBMD_D_B2_HI    = 32'h2000_7FFF;
  localparam logic [31:0] SBMD_D_B36_LO   = 32'h2004_0000;
  localparam logic [31:0] SBMD_D_B36_HI   = 32'h2005_3FFF;
  localparam logic [31:0] SBMD_D_B7_LO    = 32'h2005_4000;
  localparam logic [31:0] SBMD_D_B7_HI    = 32'h2005_7FFF;

  // Physical word base of each bank in the shared array
  localparam logic [14:0] SBMD_P_B0       = 15'h0000;
  localparam logic [14:0] SBMD_P_B1       = 15'h1000;
  localparam logic [14:0] SBMD_P_B2       = 15'h1C00;
  localparam logic [14:0] SBMD_P_B3       = 15'h2000;
  localparam logic [14:0] SBMD_P_B7       = 15'h7000;
  localparam int          SBMD_WORDS      = 32768;

  // Word layout
  localparam int          SBMD_DW         = 32;
  localparam int          SBMD_PW         = 4;

  // Reset values of the response flops
  localparam logic [31:0] SBMD_RDATA_RST  = 32'h0000_0000;

endpackage : sbmd_pkg

`default_nettype wire

// ==== hw/sbmd_decoder.sv ====
// Purpose: Mode-dependent address decoder, bank router and parity-protected SRAM store
// Assumes: One request port, masters arbitrated upstream; requests are same-clock signals
// Notes:   Every access is taken in one cycle; its response appears on the next edge
//          ready_o is constant high, so there is no back-pressure path to the masters.
//          Banks 1, 2 and 7 are reached from an instruction and a data window alike;
//          both windows land on the same physical words.
//          The array has no reset: a word read before its first write returns unknown
//          data and an unknown parity flag.
//          Writes to unmapped addresses are dropped and answered with err_o.
//          A mode change waits for an idle cycle, so unbroken traffic keeps the old map.
//
// Contract
// - Modes 0 and 1 map 12 KB of bank 1 at 0x1000_0000..0x1000_2FFF.
// - Modes 0 and 1 map 16 KB of bank 7 at 0x1000_3000..0x1000_6FFF.
// - Mode 0 maps bank 2 at 0x1000_7000..0x1000_7FFF; mode 1 leaves it unmapped.
// - Every mode maps 16 KB of bank 0 at 0x2000_0000..0x2000_3FFF.
// - Modes 2 and 3 map bank 1 at 0x2000_4000..0x2000_6FFF; else unmapped.
// - Mode 2 maps bank 2 at 0x2000_7000..0x2000_7FFF; mode 3 gives it to cache.
// - Every mode maps banks 3 to 6 contiguously at 0x2004_0000..0x2005_3FFF.
// - Modes 2 and 3 map bank 7 at 0x2005_4000..0x2005_7FFF; else unmapped.
// - With instruction space off, its 32 KB becomes data, 128 KB total.
// - With cache on, 4 KB of bank 2 leaves the address map.
// - Every access completes at core clock with no wait states.
// - Both reads and writes are accepted from core and DMA masters.
// - Each word carries parity bits; soft errors are flagged on read.
`default_nettype none

module sbmd_decoder
  import sbmd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Configuration
  input  wire logic [1:0]  mode_i,
  output logic      [1:0]  mode_o,
  // Request
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [31:0] wdata_i,
  output logic             ready_o,
  // Response
  output logic             rvalid_o,
  output logic [31:0]      rdata_o,
  output logic             err_o,
  output logic             perr_o
);

  // Storage: eight banks packed into one array, data plus one parity bit per byte
  logic [SBMD_DW+SBMD_PW-1:0] mem_q [0:SBMD_WORDS-1];

  // Mode and response state; next values come from one combinational block
  logic [1:0]  mode_q,   mode_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q,  rdata_d;
  logic        err_q,    err_d;
  logic        perr_q,   perr_d;

  // Decode result and array port signals
  logic        hit;
  logic [14:0] widx;
  logic        do_wr;
  logic [SBMD_DW+SBMD_PW-1:0] rd_word;
  logic [SBMD_DW+SBMD_PW-1:0] wr_word;
  logic        rd_bad;

  // Window test, inclusive at both ends
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Physical word index of an address inside a window
  function automatic logic [14:0] phys(input logic [31:0] a, input logic [31:0] lo, input logic [14:0] base);
    logic [31:0] d;
    // Byte offset inside the window; bits 1:0 drop out as word access
    d = a - lo;
    return base + d[16:2];
  endfunction

  // Even parity bit for each byte lane
  function automatic logic [SBMD_PW-1:0] par(input logic [31:0] w);
    logic [SBMD_PW-1:0] p;
    p = '0;
    for (int i = 0; i < SBMD_PW; i++) begin
      p[i] = ^w[8*i +: 8];
    end
    return p;
  endfunction

  // Address decode against the active mode; windows do not overlap so order is free
  always_comb begin
    logic instruction_sram_on;
    logic cache_on;
    instruction_sram_on = ~mode_q[SBMD_MODE_NOI];
    cache_on            = mode_q[SBMD_MODE_CACHE];
    // Defaults: a miss points at word 0, which a miss never writes
    hit  = 1'b0;
    widx = 15'h0000;
    // Bank 1 instruction window, modes 0 and 1
    if (in_rng(addr_i, SBMD_I_B1_LO, SBMD_I_B1_HI) && instruction_sram_on) begin
      hit  = 1'b1;
      widx = phys(addr_i, SBMD_I_B1_LO, SBMD_P_B1);
    end
    // Bank 7 instruction window, modes 0 and 1
    if (in_rng(addr_i, SBMD_I_B7_LO, SBMD_I_B7_HI) && instruction_sram_on) begin
      hit  = 1'b1;
      widx = phys(addr_i, SBMD_I_B7_LO, SBMD_P_B7);
    end
    // Bank 2 instruction window, mode 0 only; cache mode hides it
    if (in_rng(addr_i, SBMD_I_B2_LO, SBMD_I_B2_HI) && instruction_sram_on && !cache_on) begin
      hit  = 1'b1;
      widx = phys(addr_i, SBMD_I_B2_LO, SBMD_P_B2);
    end
    // Bank 0 data window, every mode
    if (in_rng(addr_i, SBMD_D_B0_LO, SBMD_D_B0_HI)) begin
      hit  = 1'b1;
      widx = phys(addr_i, SBMD_D_B0_LO, SBMD_P_B0);
    end
    // Bank 1 data window, aliasing its instruction words
    if (in_rng(addr_i, SBMD_D_B1_LO, SBMD_D_B1_HI) && !instruction_sram_on) begin
      hit  = 1'b1;
      widx = phys(addr_i, SBMD_D_B1_LO, SBMD_P_B1);
    end
    // Bank 2 data window, mode 2 only
    if (in_rng(addr_i, SBMD_D_B2_LO, SBMD_D_B2_HI) && !instruction_sram_on && !cache_on) begin
      hit  = 1'b1;
      widx = phys(addr_i, SBMD_D_B2_LO, SBMD_P_B2);
    end
    // Banks 3 to 6 data window, every mode, one contiguous run
    if (in_rng(addr_i, SBMD_D_B36_LO, SBMD_D_B36_HI)) begin
      hit  = 1'b1;
      widx = phys(addr_i, SBMD_D_B36_LO, SBMD_P_B3);
    end
    // Bank 7 data window, aliasing its instruction words
    if (in_rng(addr_i, SBMD_D_B7_LO, SBMD_D_B7_HI) && !instruction_sram_on) begin
      hit  = 1'b1;
      widx = phys(addr_i, SBMD_D_B7_LO, SBMD_P_B7);
    end
  end

  // Never stalls: the array answers in the cycle the request is taken
  assign ready_o = 1'b1;

  // Byte-lane merge for writes; parity recomputed over the merged word
  assign rd_word = mem_q[widx];
  assign do_wr   = req_i && we_i && hit;
  always_comb begin
    logic [31:0] m;
    m = rd_word[SBMD_DW-1:0];
    // Lanes without an enable keep the stored byte
    for (int i = 0; i < SBMD_PW; i++) begin
      if (be_i[i]) begin
        m[8*i +: 8] = wdata_i[8*i +: 8];
      end
    end
    wr_word = {par(m), m};
  end

  // Array write port; no reset since contents are not defined at power-up
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_q[widx] <= wr_word;
    end
  end

  // Stored parity against parity recomputed from the stored data; a mismatch is a soft error
  assign rd_bad = |(par(rd_word[SBMD_DW-1:0]) ^ rd_word[SBMD_DW+SBMD_PW-1:SBMD_DW]);

  // Next response and next mode
  always_comb begin
    mode_d   = mode_q;
    rvalid_d = req_i;
    rdata_d  = rdata_q;
    err_d    = 1'b0;
    perr_d   = 1'b0;
    // Switching only on idle cycles keeps a mode change from splitting an access
    if (!req_i) begin
      mode_d = mode_i;
    end
    if (req_i && !hit) begin
      // Unmapped: flag the error and clear the read data
      err_d   = 1'b1;
      rdata_d = SBMD_RDATA_RST;
    end else if (req_i && !we_i) begin
      // Mapped read: return the word with its parity verdict
      rdata_d = rd_word[SBMD_DW-1:0];
      perr_d  = rd_bad;
    end
  end

  // Response and mode registers
  // The array stays out of this reset; only the mode and the response flops clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q   <= SBMD_MODE_RST;
      rvalid_q <= 1'b0;
      rdata_q  <= SBMD_RDATA_RST;
      err_q    <= 1'b0;
      perr_q   <= 1'b0;
    end else begin
      mode_q   <= mode_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      err_q    <= err_d;
      perr_q   <= perr_d;
    end
  end

  // Outputs straight from the registers
  assign mode_o   = mode_q;
  assign rvalid_o = rvalid_q;
  assign rdata_o  = rdata_q;
  assign err_o    = err_q;
  assign perr_o   = perr_q;

endmodule : sbmd_decoder

`default_nettype wire

// ==== bench/sbmd_properties.sv ====
// Purpose: Port-level properties of the SRAM bank mode decoder
// Assumes: One clock; each request is answered on the next edge
// Notes:   Window checks use the mode that stood during the request
`default_nettype none

module sbmd_properties (
  // Clock, reset and mode
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [1:0]  mode_i,
  input wire logic [1:0]  mode_o,
  // Request and response
  input wire logic        req_i,
  input wire logic [31:0] addr_i,
  input wire logic        ready_o,
  input wire logic        rvalid_o,
  input wire logic [31:0] rdata_o,
  input wire logic        err_o,
  input wire logic        perr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Everything on the core clock, quiet in reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Odd-sized windows need full compares, not top bits
  logic iwin;
  logic dwin36;
  logic dwin7;
  assign iwin   = req_i && addr_i >= 32'h1000_0000 && addr_i <= 32'h1000_6FFF;
  assign dwin36 = req_i && addr_i >= 32'h2004_0000 && addr_i <= 32'h2005_3FFF;
  assign dwin7  = req_i && addr_i >= 32'h2005_4000 && addr_i <= 32'h2005_7FFF;

  chk_ready_high: assert property (ready_o)
    else $error("ready dropped");
  chk_resp_next: assert property (req_i |=> rvalid_o)
    else $error("no response one cycle after request");
  chk_resp_none: assert property (!req_i |=> !rvalid_o)
    else $error("response without request");
  chk_err_data: assert property (err_o |-> rvalid_o && rdata_o == 32'h0)
    else $error("error without response or with data");
  chk_perr_hit: assert property (perr_o |-> rvalid_o && !err_o)
    else $error("parity flag outside a read hit");
  chk_mode_hold: assert property (req_i |=> $stable(mode_o))
    else $error("mode changed during traffic");
  chk_mode_load: assert property ((!req_i && nrst_i) |=> mode_o == $past(mode_i))
    else $error("mode not loaded on idle edge");
  chk_iwin_map: assert property (iwin |=> err_o == $past(mode_o[1]))
    else $error("instruction window decode wrong");
  chk_b36_map: assert property (dwin36 |=> !err_o)
    else $error("banks 3 to 6 not mapped");
  chk_b7_map: assert property (dwin7 |=> err_o == !$past(mode_o[1]))
    else $error("bank 7 data window decode wrong");
  // Main scenarios
  cov_burst: cover property (req_i ##1 req_i ##1 req_i);
  cov_err: cover property (rvalid_o && err_o);
  cov_mode: cover property (!req_i && mode_i != mode_o);
endmodule // sbmd_properties

bind sbmd_decoder sbmd_properties i_sbmd_properties (
  .clk_i(clk_i), .nrst_i(nrst_i), .mode_i(mode_i), .mode_o(mode_o), .req_i(req_i),
  .addr_i(addr_i), .ready_o(ready_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
  .err_o(err_o), .perr_o(perr_o));

`default_nettype wire

// ==== bench/sbmd_master.sv ====
// Purpose: Bus master model on the decoder request port
// Assumes: Ready never drops, so one edge takes each request
// Notes:   Idle cycles flip address and data so stale values never look valid
`default_nettype none

module sbmd_master (
  // Clock and response
  input  wire logic        clk_i,
  input  wire logic        rvalid_i,
  input  wire logic        err_i,
  input  wire logic        perr_i,
  input  wire logic [31:0] rdata_i,
  // Request
  output var  logic        req_o,
  output var  logic        we_o,
  output var  logic [31:0] addr_o,
  output var  logic [3:0]  be_o,
  output var  logic [31:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [33:0] rsp_q[$];
  // Queue responses so back-to-back traffic is judged afterwards
  always @(posedge clk_i) if (rvalid_i === 1'b1) rsp_q.push_back({perr_i, err_i, rdata_i});
  initial {req_o, we_o, addr_o, be_o, wdata_o} = '0;
  // One access, reads and writes alike
  task automatic put(input logic w, input logic [31:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_i);
    req_o <= 1'b1;
    // Memory words hold no reserved bits, so each write carries its lanes as given
    {we_o, addr_o, be_o, wdata_o} <= {w, a, b, d};
  endtask
  // Release the request
  task automatic idle();
    @(posedge clk_i);
    req_o <= 1'b0;
    {addr_o, wdata_o} <= ~{addr_o, wdata_o};
  endtask
endmodule // sbmd_master

`default_nettype wire

// ==== bench/sbmd_decoder_tb_top.sv ====
// Purpose: Self-checking bench for the SRAM bank mode decoder
// Assumes: Master model drives requests; bench drives mode and reset
// Notes:   Each window edge is written and read back in every mode
`default_nettype none

module sbmd_decoder_tb_top;
  import sbmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, nrst_i, req_i, we_i, ready_o, rvalid_o, err_o, perr_o;
  logic [1:0]  mode_i, mode_o;
  logic [3:0]  be_i;
  logic [31:0] addr_i, wdata_i, rdata_o;
  int          mismatches = 0;
  int          tests_run = 0;
  // Window edges and neighbours; bit m set when mode m maps the address
  logic [31:0] a_t [20] = '{32'h1000_0000, 32'h1000_2FFC, 32'h1000_3000, 32'h1000_6FFC, 32'h1000_7000,
    32'h1000_7FFC, 32'h1000_8000, 32'h2000_0000, 32'h2000_3FFC, 32'h2000_4000, 32'h2000_6FFC, 32'h2000_7000,
    32'h2000_7FFC, 32'h2000_8000, 32'h2003_FFFC, 32'h2004_0000, 32'h2005_3FFC, 32'h2005_4000, 32'h2005_7FFC,
    32'h2005_8000};
  logic [3:0]  m_t [20] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h1, 4'h1, 4'h0, 4'hF, 4'hF, 4'hC, 4'hC, 4'h4, 4'h4,
    4'h0, 4'h0, 4'hF, 4'hF, 4'hC, 4'hC, 4'h0};

  sbmd_decoder i_sbmd_decoder (.clk_i(clk_i), .nrst_i(nrst_i), .mode_i(mode_i), .mode_o(mode_o),
    .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .be_i(be_i), .wdata_i(wdata_i), .ready_o(ready_o),
    .rvalid_o(rvalid_o), .rdata_o(rdata_o), .err_o(err_o), .perr_o(perr_o));
  sbmd_master i_sbmd_master (.clk_i(clk_i), .rvalid_i(rvalid_o), .err_i(err_o), .perr_i(perr_o), .rdata_i(rdata_o),
    .req_o(req_i), .we_o(we_i), .addr_o(addr_i), .be_o(be_i), .wdata_o(wdata_i));

  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Two idle edges let the last response land in the queue
  task automatic drain();
    i_sbmd_master.idle();
    i_sbmd_master.idle();
    #1;
  endtask
  // Write responses keep old read data or zero on a miss, so only the flags count there; parity never trips
  task automatic rsp(input logic e, input logic [31:0] d, input logic wr);
    logic [33:0] r;
    check(37'(i_sbmd_master.rsp_q.size() > 0), 37'h1);
    r = i_sbmd_master.rsp_q.pop_front();
    if (wr) r[31:0] = d;
    check(37'(r), {3'h0, 1'b0, e, d});
  endtask
  task automatic set_mode(input logic [1:0] m);
    mode_i <= m;
    drain();
    check(37'(mode_o), 37'(m));
  endtask
  task automatic t_map();
    logic [31:0] d;
    logic        hit;
    for (int m = 0; m < 4; m++) begin
      set_mode(2'(m));
      for (int i = 0; i < 20; i++) begin
        d = ~a_t[i] + 32'(m);
        hit = m_t[i][m];
        i_sbmd_master.put(1'b1, a_t[i], 4'hF, d);
        i_sbmd_master.put(1'b0, a_t[i], 4'h0, 32'h0);
        drain();
        rsp(!hit, d, 1'b1);
        rsp(!hit, hit ? d : 32'h0, 1'b0);
      end
    end
  endtask
  // Cache mode drops the write; data mode reaches the same bank 2 word
  task automatic t_alias();
    set_mode(SBMD_MODE0);
    i_sbmd_master.put(1'b1, 32'h1000_7000, 4'hF, 32'hCAFE_0001);
    set_mode(SBMD_MODE1);
    i_sbmd_master.put(1'b1, 32'h1000_7000, 4'hF, 32'h0BAD_0002);
    set_mode(SBMD_MODE2);
    i_sbmd_master.put(1'b0, 32'h2000_7000, 4'h0, 32'h0);
    drain();
    rsp(1'b0, 32'h0, 1'b1);
    rsp(1'b1, 32'h0, 1'b1);
    rsp(1'b0, 32'hCAFE_0001, 1'b0);
  endtask
  task automatic t_b2b();
    i_sbmd_master.put(1'b1, 32'h2004_8000, 4'hF, 32'h1122_3344);
    i_sbmd_master.put(1'b1, 32'h2004_8000, 4'h5, 32'hAABB_CCDD);
    i_sbmd_master.put(1'b0, 32'h2004_8000, 4'h0, 32'h0);
    drain();
    rsp(1'b0, 32'h0, 1'b1);
    rsp(1'b0, 32'h0, 1'b1);
    rsp(1'b0, 32'h11BB_33DD, 1'b0);
  endtask
  // A mode request under continuous traffic waits for the first idle edge
  task automatic t_hold();
    set_mode(SBMD_MODE0);
    i_sbmd_master.put(1'b0, 32'h2000_4000, 4'h0, 32'h0);
    mode_i <= SBMD_MODE2;
    i_sbmd_master.put(1'b0, 32'h2000_4000, 4'h0, 32'h0);
    i_sbmd_master.put(1'b0, 32'h2000_4000, 4'h0, 32'h0);
    #1;
    check(37'(mode_o), 37'(SBMD_MODE0));
    drain();
    for (int i = 0; i < 3; i++) rsp(1'b1, 32'h0, 1'b0);
    check(37'(mode_o), 37'(SBMD_MODE2));
  endtask
  // Reset in mid-run clears the flops and the mode while mode_i still asks for mode 2
  task automatic t_reset();
    set_mode(SBMD_MODE2);
    i_sbmd_master.put(1'b0, 32'h2004_8000, 4'h0, 32'h0);
    drain();
    rsp(1'b0, 32'h11BB_33DD, 1'b0);
    @(posedge clk_i) nrst_i <= 1'b0;
    #1;
    check({mode_o, rvalid_o, err_o, perr_o, rdata_o}, 37'h0);
    @(posedge clk_i) nrst_i <= 1'b1;
    drain();
    check(37'(mode_o), 37'(SBMD_MODE2));
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Whole run needs well under ten thousand cycles
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial begin
    mode_i = SBMD_MODE0;
    nrst_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    check({mode_o, rvalid_o, err_o, perr_o, rdata_o}, 37'h0);
    @(posedge clk_i) nrst_i <= 1'b1;
    t_map();
    t_alias();
    t_b2b();
    t_hold();
    t_reset();
    give_verdict();
  end
endmodule // sbmd_decoder_tb_top

`default_nettype wire
